// ===== core/crypto_ctl.sv
// Control and status registers and sequencing of the crypto engine.
// Assumes a datapath that reports done, input consumed and counter
// wrap, and an array reader that pulses its own done.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "crypto_ctl_params.svh"
module crypto_ctl #(
  parameter int CTR_W = 7
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic module_power_down_i,
  input wire logic idle_mode_i,
  input wire crypto_ctl_pkg::engine_ev_t engine_ev_i,
  input wire logic text_a_in_use_i,
  input wire logic key_cfg_bad_i,
  input wire logic [8:0] page_locked_i,
  input wire logic array_read_done_i,
  input wire logic program_done_i,
  output logic engine_run_o,
  output logic engine_abort_o,
  output crypto_ctl_pkg::cfg_t engine_cfg_o,
  output logic cipher_aes_o,
  output logic program_run_o,
  output logic array_read_run_o,
  output logic [CTR_W-1:0] counter_width_select_o,
  output logic irq_o
);
  logic clr;
  logic engine_enable_r;
  logic idle_stop_r;
  logic wrap_irq_enable_r;
  logic finish_irq_enable_r;
  logic input_free_irq_enable_r;
  logic engine_go_r;
  crypto_ctl_pkg::cfg_t cfg_r;
  logic abort_flag_r;
  logic counter_wrap_flag_r;
  logic program_start_r;
  logic array_read_r;
  logic [3:0] program_page_select_r;
  logic [CTR_W-1:0] ctr_size_r;
  crypto_ctl_pkg::state_t state_r;
  crypto_ctl_pkg::state_t state_nxt;
  logic [15:0] rdata_r;
  logic irq_r;
  logic mode_fault;
  logic key_fault;
  logic page_fault;
  logic op_ok;
  logic chain_ok;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_prog;
  logic go_set;
  logic sw_stop;
  logic idle_halt;
  logic prog_set;
  logic stop_now;
  logic new_page_bad;

  // Power-down acts as a reset of all control and status
  assign clr = sys_rst_i | module_power_down_i; // R10
  assign wr_ctrl = wr_i && addr_i == `ADDR_CTRL_LOW;
  assign wr_stat = wr_i && addr_i == `ADDR_STATUS;
  assign wr_prog = wr_i && addr_i == `ADDR_PROG_CTRL;
  assign idle_halt = idle_mode_i & idle_stop_r; // R2
  assign sw_stop = wr_ctrl & engine_go_r & ~wdata_i[`BIT_GO];

  // Decode of valid operation and chaining codes
  always_comb
  begin
    case (cfg_r.op)
      crypto_ctl_pkg::OP_ENCRYPT, crypto_ctl_pkg::OP_DECRYPT,
      crypto_ctl_pkg::OP_KEY_EXPAND, crypto_ctl_pkg::OP_RANDOM,
      crypto_ctl_pkg::OP_SKEY_GEN, crypto_ctl_pkg::OP_SKEY_ENC,
      crypto_ctl_pkg::OP_SKEY_LOAD: op_ok = 1'b1; // R11 R12
      default: op_ok = 1'b0;
    endcase
    chain_ok = cfg_r.chain <= crypto_ctl_pkg::CM_CTR; // R14
  end

  // Faults are combinational so they work with the engine off
  assign mode_fault = ~op_ok | ~chain_ok; // R18 R21
  assign key_fault = key_cfg_bad_i | array_read_r; // R19 R22
  assign page_fault = array_read_r | program_page_select_r > `LAST_PAGE
    | (program_page_select_r <= `LAST_PAGE
    && page_locked_i[program_page_select_r]); // R20 R22

  // Enable and go may arrive in one word, so the written enable counts
  assign go_set = wr_ctrl & wdata_i[`BIT_GO] & ~engine_go_r & wdata_i[`BIT_ENABLE]
    & ~abort_flag_r & ~counter_wrap_flag_r & ~mode_fault & ~idle_halt; // R1 R8 R17
  // Judge the page being written, else a locked page could start
  assign new_page_bad = wdata_i[4:1] > `LAST_PAGE
    | (wdata_i[4:1] <= `LAST_PAGE && page_locked_i[wdata_i[4:1]]); // R20
  assign prog_set = wr_prog & wdata_i[`BIT_PROG_START] & ~program_start_r
    & engine_enable_r & ~engine_go_r & ~mode_fault & ~key_fault
    & ~new_page_bad; // R18 R19 R20
  assign stop_now = sw_stop | idle_halt | ~engine_enable_r; // R2 R7

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      crypto_ctl_pkg::ST_IDLE:
      begin
        if (go_set)
          state_nxt = crypto_ctl_pkg::ST_RUN; // R6
        else if (prog_set)
          state_nxt = crypto_ctl_pkg::ST_PROG; // R24
      end
      crypto_ctl_pkg::ST_RUN:
      begin
        if (stop_now || engine_ev_i.done)
          state_nxt = crypto_ctl_pkg::ST_IDLE;
      end
      crypto_ctl_pkg::ST_PROG:
      begin
        if (program_done_i || idle_halt)
          state_nxt = crypto_ctl_pkg::ST_IDLE;
      end
      default: state_nxt = crypto_ctl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      state_r <= crypto_ctl_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Go mirrors the run state; hardware clears it on completion
  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      engine_go_r <= 1'b0;
    else
      engine_go_r <= state_nxt == crypto_ctl_pkg::ST_RUN; // R6
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
    begin
      engine_enable_r <= 1'b0;
      idle_stop_r <= 1'b0;
      wrap_irq_enable_r <= 1'b0;
      finish_irq_enable_r <= 1'b0;
      input_free_irq_enable_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      engine_enable_r <= wdata_i[`BIT_ENABLE]; // R1
      idle_stop_r <= wdata_i[`BIT_IDLE_STOP]; // R2
      wrap_irq_enable_r <= wdata_i[`BIT_WRAP_IE]; // R3
      finish_irq_enable_r <= wdata_i[`BIT_FINISH_IE]; // R4
      input_free_irq_enable_r <= wdata_i[`BIT_FREE_IE]; // R5
    end
  end

  // Mode fields frozen while an operation runs
  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      cfg_r <= '0;
    else if (wr_ctrl && !engine_go_r)
      cfg_r <= wdata_i[7:0]; // R9
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      ctr_size_r <= '0;
    else if (wr_i && addr_i == `ADDR_CTR_SIZE && !engine_go_r)
      ctr_size_r <= wdata_i[CTR_W-1:0]; // R23
  end

  // Abort: set wins over a same-cycle clear
  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      abort_flag_r <= 1'b0;
    else if (state_r == crypto_ctl_pkg::ST_RUN && sw_stop)
      abort_flag_r <= 1'b1; // R7
    else if (wr_stat && !wdata_i[`BIT_ABORT])
      abort_flag_r <= 1'b0; // R8
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      counter_wrap_flag_r <= 1'b0;
    else if (state_r == crypto_ctl_pkg::ST_RUN && engine_ev_i.wrap
      && cfg_r.chain == crypto_ctl_pkg::CM_CTR)
      counter_wrap_flag_r <= 1'b1; // R17 R23
    else if (wr_stat && !wdata_i[`BIT_WRAP])
      counter_wrap_flag_r <= 1'b0; // R17
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
    begin
      program_page_select_r <= 4'h0;
      array_read_r <= 1'b0;
    end
    else
    begin
      if (wr_prog && state_r != crypto_ctl_pkg::ST_PROG)
        program_page_select_r <= wdata_i[4:1];
      // Done beats a same-cycle request
      if (array_read_done_i)
        array_read_r <= 1'b0;
      else if (wr_prog && wdata_i[`BIT_ARRAY_READ] && engine_enable_r && !engine_go_r)
        array_read_r <= 1'b1; // R22
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      program_start_r <= 1'b0;
    else
      program_start_r <= state_nxt == crypto_ctl_pkg::ST_PROG; // R24
  end

  // Single-cycle events, only while an operation runs
  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      irq_r <= 1'b0;
    else
      irq_r <= state_r == crypto_ctl_pkg::ST_RUN && !stop_now
        && ((wrap_irq_enable_r && engine_ev_i.wrap) // R3
        || (finish_irq_enable_r && engine_ev_i.done) // R4
        || (input_free_irq_enable_r && engine_ev_i.input_free)); // R25 R5
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      rdata_r <= 16'h0000;
    else if (!rd_i)
      rdata_r <= 16'h0000;
    else
    begin
      case (addr_i)
        `ADDR_CTRL_LOW: rdata_r <= {engine_enable_r, 1'b0, idle_stop_r,
          wrap_irq_enable_r, finish_irq_enable_r, input_free_irq_enable_r,
          1'b0, engine_go_r, cfg_r};
        `ADDR_STATUS: rdata_r <= {8'h00,
          engine_go_r | array_read_r, // R15 R22
          text_a_in_use_i, // R16
          abort_flag_r, counter_wrap_flag_r, 1'b0,
          mode_fault, key_fault, page_fault};
        `ADDR_PROG_CTRL: rdata_r <= {10'h000, array_read_r,
          program_page_select_r, program_start_r};
        `ADDR_CTR_SIZE: rdata_r <= 16'(ctr_size_r);
        default: rdata_r <= 16'h0000;
      endcase
    end
  end

  assign rdata_o = rdata_r;
  assign engine_run_o = engine_go_r;
  assign engine_abort_o = abort_flag_r;
  assign engine_cfg_o = cfg_r;
  assign cipher_aes_o = cfg_r.cipher; // R13
  assign program_run_o = program_start_r;
  assign array_read_run_o = array_read_r;
  assign counter_width_select_o = ctr_size_r;
  assign irq_o = irq_r;
endmodule

// ===== pkg/crypto_ctl_params.svh
// Offsets, field positions, reset values and codes of the engine control block.
// Assumes a 16-bit register port with word indices below.
// What this block does
// R1: Enable bit 15 turns engine on
// R2: Idle stop bit 13 halts in Idle
// R3: Wrap enable bit 12 raises wrap event
// R4: Finish enable bit 11 raises done event
// R5: Input-free enable bit 10 raises event
// R6: Go bit 8 starts; hardware clears
// R7: Software clearing go aborts, sets abort
// R8: Abort flag blocks operations; write clears
// R9: Mode fields locked while go set
// R10: Reset or power-down clears control, status
// R11: Session key codes 1111, 1110, 1011
// R12: Codes 1010, 0010, 0001, 0000; others reserved
// R13: Cipher bit 3 picks AES or DES
// R14: Chaining codes 100..000; 101, 11x reserved
// R15: Busy bit 7 shows operation running
// R16: Text A busy bit 6 while used
// R17: Wrap flag set on rollover, blocks go
// R18: Mode fault on invalid combination, blocks programming
// R19: Key fault on invalid key, blocks programming
// R20: Page fault on reserved/locked page
// R21: Fault checks run while disabled
// R22: Array read forces busy, key, page faults
// R23: Counter in text B, width selectable
// R24: Program start writes text C, self-clears
// R25: Enabled events pulse onto one request
`ifndef CRYPTO_CTL_PARAMS_SVH
`define CRYPTO_CTL_PARAMS_SVH
`define ADDR_CTRL_LOW 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_PROG_CTRL 4'h2
`define ADDR_CTR_SIZE 4'h3
`define RST_CTRL_LOW 16'h0000
`define RST_STATUS 8'h00
`define BIT_ENABLE 15
`define BIT_IDLE_STOP 13
`define BIT_WRAP_IE 12
`define BIT_FINISH_IE 11
`define BIT_FREE_IE 10
`define BIT_GO 8
`define BIT_BUSY 7
`define BIT_TXTA_BUSY 6
`define BIT_ABORT 5
`define BIT_WRAP 4
`define BIT_MODE_FAULT 2
`define BIT_KEY_FAULT 1
`define BIT_PAGE_FAULT 0
`define BIT_PROG_START 0
`define BIT_ARRAY_READ 5
`define LAST_PAGE 4'h8
`endif

// ===== pkg/crypto_ctl_pkg.sv
// Types of the engine control block.
// Assumes the params header for numeric positions.
package crypto_ctl_pkg;
  typedef enum logic [3:0] {
    OP_ENCRYPT = 4'h0,
    OP_DECRYPT = 4'h1,
    OP_KEY_EXPAND = 4'h2,
    OP_RANDOM = 4'hA,
    OP_SKEY_GEN = 4'hB,
    OP_SKEY_ENC = 4'hE,
    OP_SKEY_LOAD = 4'hF
  } op_sel_t;
  typedef enum logic [2:0] {
    CM_ECB = 3'h0,
    CM_CBC = 3'h1,
    CM_CFB = 3'h2,
    CM_OFB = 3'h3,
    CM_CTR = 3'h4
  } chain_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_PROG = 3'b100
  } state_t;
  typedef struct packed {
    logic [3:0] op;
    logic cipher;
    logic [2:0] chain;
  } cfg_t;
  typedef struct packed {
    logic done;
    logic input_free;
    logic wrap;
  } engine_ev_t;
endpackage

// ===== tb/crypto_ctl_sva.sv
// Assertion checker of the engine control block, bound to its top.
// Assumes the word map and bit positions of the params header.
`timescale 1ns/1ps
`include "crypto_ctl_params.svh"
module crypto_ctl_sva #(
  parameter int CTR_W = 7
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic module_power_down_i,
  input wire logic idle_mode_i,
  input wire crypto_ctl_pkg::engine_ev_t engine_ev_i,
  input wire logic text_a_in_use_i,
  input wire logic key_cfg_bad_i,
  input wire logic [8:0] page_locked_i,
  input wire logic array_read_done_i,
  input wire logic program_done_i,
  input wire logic engine_run_o,
  input wire logic engine_abort_o,
  input wire crypto_ctl_pkg::cfg_t engine_cfg_o,
  input wire logic cipher_aes_o,
  input wire logic program_run_o,
  input wire logic array_read_run_o,
  input wire logic [CTR_W-1:0] counter_width_select_o,
  input wire logic irq_o
);
  logic [15:0] ctl_r;
  logic wr_ctl;
  logic stop_now;
  assign wr_ctl = wr_i && (addr_i == `ADDR_CTRL_LOW);
  assign stop_now = wr_ctl || module_power_down_i || (idle_mode_i && ctl_r[`BIT_IDLE_STOP]);
  // Shadow of control writes; enable bits are never locked
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || module_power_down_i)
    begin
      ctl_r <= 16'h0000;
    end
    else if (wr_ctl)
    begin
      ctl_r <= wdata_i;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_go_done;
    engine_run_o && engine_ev_i.done && !wr_ctl |=> !engine_run_o;
  endproperty
  a_go_done: assert property (p_go_done) else $error("go not cleared by done");
  property p_abort;
    engine_run_o && wr_ctl && !wdata_i[`BIT_GO] && !engine_ev_i.done && !module_power_down_i
      |=> engine_abort_o && !engine_run_o;
  endproperty
  a_abort: assert property (p_abort) else $error("go clear did not abort");
  property p_abort_blocks;
    engine_abort_o && !engine_run_o |=> !engine_run_o;
  endproperty
  a_abort_blocks: assert property (p_abort_blocks) else $error("started while aborted");
  property p_cfg_lock;
    engine_run_o && !module_power_down_i |=> $stable(engine_cfg_o) && $stable(cipher_aes_o);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("config changed while running");
  property p_pd_clear;
    module_power_down_i |=> !engine_run_o && !engine_abort_o && !irq_o && engine_cfg_o == '0;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("power-down did not clear");
  property p_busy_read;
    rd_i && addr_i == `ADDR_STATUS && !module_power_down_i |=> rdata_o[15:8] == 8'h00
      && rdata_o[`BIT_BUSY] == ($past(engine_run_o) | $past(array_read_run_o));
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");
  property p_idle;
    engine_run_o && idle_mode_i && ctl_r[`BIT_IDLE_STOP] && !wr_ctl |=> !engine_run_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle did not stop");
  property p_done_irq;
    engine_run_o && engine_ev_i.done && ctl_r[`BIT_FINISH_IE] && ctl_r[`BIT_ENABLE]
      && !stop_now |=> irq_o;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done event missing");
  property p_irq_cause;
    irq_o |-> $past(engine_ev_i) != 3'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without event");
endmodule
bind crypto_ctl crypto_ctl_sva #(.CTR_W(CTR_W)) u_sva (.*);

// ===== tb/crypto_ctl_tb.sv
// Self-checking bench of the engine control block.
// Assumes one-cycle strobes and registered read data and events.
`timescale 1ns/1ps
`include "crypto_ctl_params.svh"
module crypto_ctl_tb;
  logic ref_clk_i, sys_rst_i, wr_i, rd_i, module_power_down_i, idle_mode_i;
  logic text_a_in_use_i, key_cfg_bad_i, array_read_done_i, program_done_i;
  logic engine_run_o, engine_abort_o, cipher_aes_o, program_run_o, array_read_run_o, irq_o;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic [8:0] page_locked_i;
  logic [6:0] counter_width_select_o;
  crypto_ctl_pkg::engine_ev_t engine_ev_i;
  crypto_ctl_pkg::cfg_t engine_cfg_o;
  int fail_count = 0;
  int check_count = 0;
  int i;
  crypto_ctl dut (.*);
  always #20 ref_clk_i = ~ref_clk_i;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  // One-cycle pulse on {idle, program done, array read done, power-down}
  task pls(input logic [3:0] m);
    @(posedge ref_clk_i);
    {idle_mode_i, program_done_i, array_read_done_i, module_power_down_i} <= m;
    @(posedge ref_clk_i);
    {idle_mode_i, program_done_i, array_read_done_i, module_power_down_i} <= 4'h0;
    #1;
  endtask
  // Event pulse, then the single request cycle is judged
  task ev(input logic [2:0] e, input logic [15:0] exp);
    @(posedge ref_clk_i);
    engine_ev_i <= e;
    @(posedge ref_clk_i);
    engine_ev_i <= 3'h0;
    #1 chk(16'(irq_o), exp);
  endtask
  task t_run;
    wr(`ADDR_CTRL_LOW, 16'h8D0C);
    chk(16'(engine_run_o), 16'h0001);
    chk(16'(cipher_aes_o), 16'h0001);
    rd(`ADDR_STATUS, 16'h0080);
    wr(`ADDR_CTRL_LOW, 16'h8D10);
    chk(16'(engine_cfg_o), 16'h000C);
    ev(3'h2, 16'h0001);
    ev(3'h4, 16'h0001);
    rd(`ADDR_CTRL_LOW, 16'h8C0C);
    rd(`ADDR_STATUS, 16'h0000);
  endtask
  task t_abort;
    wr(`ADDR_CTRL_LOW, 16'h8100);
    wr(`ADDR_CTRL_LOW, 16'h8000);
    chk(16'(engine_abort_o), 16'h0001);
    rd(`ADDR_STATUS, 16'h0020);
    wr(`ADDR_CTRL_LOW, 16'h8100);
    chk(16'(engine_run_o), 16'h0000);
    wr(`ADDR_STATUS, 16'h0000);
    rd(`ADDR_STATUS, 16'h0000);
    wr(`ADDR_CTRL_LOW, 16'h0100);
    chk(16'(engine_run_o), 16'h0000);
  endtask
  task t_wrap;
    wr(`ADDR_CTRL_LOW, 16'h9104);
    chk(16'(cipher_aes_o), 16'h0000);
    ev(3'h2, 16'h0000);
    ev(3'h1, 16'h0001);
    ev(3'h4, 16'h0000);
    rd(`ADDR_STATUS, 16'h0010);
    wr(`ADDR_CTRL_LOW, 16'h9104);
    chk(16'(engine_run_o), 16'h0000);
    wr(`ADDR_STATUS, 16'h0000);
    rd(`ADDR_STATUS, 16'h0000);
  endtask
  task t_idle;
    wr(`ADDR_CTRL_LOW, 16'h8100);
    pls(4'h8);
    chk(16'(engine_run_o), 16'h0001);
    ev(3'h4, 16'h0000);
    wr(`ADDR_CTRL_LOW, 16'hA100);
    pls(4'h8);
    chk(16'(engine_run_o), 16'h0000);
    wr(`ADDR_STATUS, 16'h0000);
  endtask
  task t_fault;
    for (i = 0; i < 16; i++)
    begin
      wr(`ADDR_CTRL_LOW, 16'(i << 4));
      rd(`ADDR_STATUS, (i > 2 && i < 14 && i / 2 != 5) ? 16'h0004 : 16'h0000);
    end
    for (i = 0; i < 8; i++)
    begin
      wr(`ADDR_CTRL_LOW, 16'(i));
      rd(`ADDR_STATUS, (i > 4) ? 16'h0004 : 16'h0000);
    end
    wr(`ADDR_CTRL_LOW, 16'h8130);
    chk(16'(engine_run_o), 16'h0000);
  endtask
  task t_side;
    wr(`ADDR_CTRL_LOW, 16'h0000);
    text_a_in_use_i <= 1'b1;
    key_cfg_bad_i <= 1'b1;
    rd(`ADDR_STATUS, 16'h0042);
    text_a_in_use_i <= 1'b0;
    key_cfg_bad_i <= 1'b0;
    page_locked_i <= 9'h004;
    wr(`ADDR_CTRL_LOW, 16'h8000);
    wr(`ADDR_PROG_CTRL, 16'h0012);
    rd(`ADDR_STATUS, 16'h0001);
    wr(`ADDR_PROG_CTRL, 16'h0005);
    chk(16'(program_run_o), 16'h0000);
    wr(`ADDR_PROG_CTRL, 16'h0003);
    chk(16'(program_run_o), 16'h0001);
    pls(4'h4);
    chk(16'(program_run_o), 16'h0000);
    wr(`ADDR_PROG_CTRL, 16'h0020);
    chk(16'(array_read_run_o), 16'h0001);
    rd(`ADDR_STATUS, 16'h0083);
    pls(4'h2);
    rd(`ADDR_STATUS, 16'h0000);
    wr(`ADDR_CTR_SIZE, 16'h007F);
    chk(16'(counter_width_select_o), 16'h007F);
    wr(`ADDR_CTRL_LOW, 16'h8100);
    pls(4'h1);
    rd(`ADDR_CTRL_LOW, 16'h0000);
  endtask
  task give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial
  begin
    {ref_clk_i, wr_i, rd_i, module_power_down_i, idle_mode_i, text_a_in_use_i} = '0;
    {key_cfg_bad_i, array_read_done_i, program_done_i, addr_i, wdata_i} = '0;
    page_locked_i = 9'h000;
    engine_ev_i = 3'h0;
    sys_rst_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(`ADDR_CTRL_LOW, 16'h0000);
    rd(`ADDR_STATUS, 16'h0000);
    t_run();
    t_abort();
    t_wrap();
    t_idle();
    t_fault();
    t_side();
    give_verdict();
  end
endmodule
